// file: fpexc_pipe_model.sv
`timescale 1ns/100ps
module fpexc_pipe_model
  import fpexc_pkg::*;
(
  // Clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       reset_i,
  // Completion request
  input  wire logic                       issue_i,
  input  wire fpexc_pkg::fpexc_flags_type flags_i,
  // Completion to the status block
  output fpexc_pkg::fpexc_done_type       done_o
);
  // Idle flags invert so stale values never pass for a report
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      done_o <= '0;
    end else begin
      done_o <= issue_i ? {1'b1, flags_i} : {1'b0, ~done_o.flags};
    end
  end
endmodule : fpexc_pipe_model

// file: fpexc_pkg.sv
package fpexc_pkg;

  // Register geometry
  localparam int STATUS_W   = 32;
  localparam int FIELD_W    = 4;
  localparam int NUM_FIELDS = 8;

  // Bit positions, bit 0 is the most significant bit
  localparam int BIT_EXC_SUMMARY      = 0;
  localparam int BIT_ENABLED_SUMMARY  = 1;
  localparam int BIT_INVALID_SUMMARY  = 2;
  localparam int BIT_OVERFLOW         = 3;
  localparam int BIT_UNDERFLOW        = 4;
  localparam int BIT_ZERO_DIVIDE      = 5;
  localparam int BIT_INEXACT          = 6;
  localparam int BIT_INV_SNAN         = 7;
  localparam int BIT_INV_INF_MINUS    = 8;
  localparam int BIT_INV_INF_DIV      = 9;
  localparam int BIT_INV_ZERO_DIV     = 10;
  localparam int BIT_INV_INF_TIMES    = 11;
  localparam int BIT_INV_COMPARE      = 12;
  localparam int BIT_INVALID_ENABLE   = 24;
  localparam int BIT_OVERFLOW_ENABLE  = 25;
  localparam int BIT_UNDERFLOW_ENABLE = 26;
  localparam int BIT_ZERO_DIV_ENABLE  = 27;
  localparam int BIT_INEXACT_ENABLE   = 28;

  // Masks over the word, written with bit 0 leftmost
  localparam logic [0:31] EXC_MASK      = 32'h1FF8_0000;
  localparam logic [0:31] INVALID_MASK  = 32'h01F8_0000;
  localparam logic [0:31] IMPL_MASK     = 32'hFFF8_00F8;
  localparam logic [0:31] WRITABLE_MASK = 32'h9FF8_00F8;
  localparam logic [0:31] CLEARABLE     = 32'h9FF8_0000;
  localparam logic [0:31] STATUS_RESET  = 32'h0000_0000;
  localparam logic [0:3]  CR_FIELD_RESET = 4'h0;

  // Status instruction codes, one-hot
  typedef enum logic [5:0] {
    FPEXC_OP_NONE                        = 6'h01,
    FPEXC_OP_MOVE_FIELDS                 = 6'h02,
    FPEXC_OP_MOVE_IMM                    = 6'h04,
    FPEXC_OP_SET_STATUS_BIT_ONE_INSTR    = 6'h08,
    FPEXC_OP_CLEAR_STATUS_BIT_ZERO_INSTR = 6'h10,
    FPEXC_OP_READ_FIELD_TO_CR            = 6'h20
  } fpexc_op_type;

  typedef struct packed {
    fpexc_op_type op;
    logic [0:7]   field_mask;
    logic [2:0]   field_idx;
    logic [0:3]   imm;
    logic [4:0]   bit_idx;
    logic [0:31]  data;
  } fpexc_cmd_type;

  typedef struct packed {
    logic overflow_flag;
    logic underflow_flag;
    logic zero_divide_flag;
    logic inexact_flag;
    logic invalid_signalling_nan_flag;
    logic invalid_inf_minus_inf_flag;
    logic invalid_inf_div_inf_flag;
    logic invalid_zero_div_zero_flag;
    logic invalid_inf_times_zero_flag;
    logic invalid_compare_flag;
  } fpexc_flags_type;

  typedef struct packed {
    logic            valid;
    fpexc_flags_type flags;
  } fpexc_done_type;

endpackage : fpexc_pkg

// file: fpexc_status.sv
`timescale 1ns/100ps
// Overview of operation
// (RULE1) A completing arithmetic, compare or round-to-single op that raises any flag sets bit 0.
// (RULE2) A set-bit-to-one instruction that raises any flag also sets bit 0.
// (RULE3) The field read-out to the condition register clears bit 0 when it reads it.
// (RULE4) Move-fields, move-immediate, set-bit and clear-bit may write bit 0 to either value.
// (RULE5) Bit 1 is the OR of every exception flag ANDed with its own enable.
// (RULE6) Bit 2 is the OR of all invalid-operation subclass flags.
// (RULE7) Overflow, underflow, zero-divide and inexact flags sit in bits 3, 4, 5 and 6.
// (RULE8) Signalling NaN, inf-inf, inf/inf and 0/0 invalid flags sit in bits 7 to 10.
// (RULE9) Inf-times-zero and invalid compare sit in bits 11 and 12 and feed bit 2.
// (RULE10) Enables sit in bits 24 to 28: invalid, overflow, underflow, zero-divide, inexact.
// (RULE11) With the machine-state enable set, a new enabled exception raises the interrupt.
// (RULE12) Bit 0 and the flags stay set until an explicit write or a clearing read-out.
module fpexc_status
  import fpexc_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     reset_i,
  input  wire logic                     ce_i,
  // Completing floating-point instruction
  input  wire fpexc_pkg::fpexc_done_type done_i,
  // Status move instructions
  input  wire fpexc_pkg::fpexc_cmd_type  cmd_i,
  // Machine-state interrupt enable
  input  wire logic                     fp_interrupt_enable_i,
  // Register view
  output logic [0:31]                   fp_status_control_o,
  // Condition register field
  output logic [0:3]                    cr_field_o,
  output logic                          cr_valid_o,
  // Precise program interrupt request
  output logic                          fp_interrupt_o
);

  import fpexc_pkg::*;

  logic [0:31] status_q;
  logic [0:31] status_d;
  logic [0:31] status_raw;
  logic [0:3]  cr_field_q;
  logic [0:3]  cr_field_d;
  logic        cr_valid_q;
  logic        cr_valid_d;
  logic        irq_q;
  logic        irq_d;
  logic        enabled_sum_new;
  logic        invalid_sum_new;

  logic [0:31] wmask;
  logic [0:31] wdata;
  logic [0:31] clr;
  logic [0:31] after_cmd;
  logic [0:31] cmd_rise;
  logic [0:31] pipe_set;
  logic [0:31] pipe_rise;
  logic        new_enabled;

  // Expand a field mask into a bit mask
  function automatic logic [0:31] field_bits(input logic [0:7] fm);
    logic [0:31] m;
    m = '0;
    for (int f = 0; f < NUM_FIELDS; f++) begin
      m[f*FIELD_W +: FIELD_W] = {FIELD_W{fm[f]}};
    end
    return m;
  endfunction : field_bits

  // One field selected by index
  function automatic logic [0:7] field_sel(input logic [2:0] idx);
    logic [0:7] fm;
    fm = '0;
    fm[idx] = 1'b1;
    return fm;
  endfunction : field_sel

  // Single bit selected by index
  function automatic logic [0:31] bit_sel(input logic [4:0] idx);
    logic [0:31] m;
    m = '0;
    m[idx] = 1'b1;
    return m;
  endfunction : bit_sel

  // Place pipeline flags at their word positions
  function automatic logic [0:31] flags_word(input fpexc_flags_type fl);
    logic [0:31] w;
    w = '0;
    w[BIT_OVERFLOW]      = fl.overflow_flag; // RULE7
    w[BIT_UNDERFLOW]     = fl.underflow_flag; // RULE7
    w[BIT_ZERO_DIVIDE]   = fl.zero_divide_flag; // RULE7
    w[BIT_INEXACT]       = fl.inexact_flag; // RULE7
    w[BIT_INV_SNAN]      = fl.invalid_signalling_nan_flag; // RULE8
    w[BIT_INV_INF_MINUS] = fl.invalid_inf_minus_inf_flag; // RULE8
    w[BIT_INV_INF_DIV]   = fl.invalid_inf_div_inf_flag; // RULE8
    w[BIT_INV_ZERO_DIV]  = fl.invalid_zero_div_zero_flag; // RULE8
    w[BIT_INV_INF_TIMES] = fl.invalid_inf_times_zero_flag; // RULE9
    w[BIT_INV_COMPARE]   = fl.invalid_compare_flag; // RULE9
    return w;
  endfunction : flags_word

  // Instruction decode and sticky update
  always_comb begin
    wmask      = '0;
    wdata      = '0;
    clr        = '0;
    unique case (cmd_i.op)
      FPEXC_OP_MOVE_FIELDS: begin
        wmask = field_bits(cmd_i.field_mask); // RULE4
        wdata = cmd_i.data;
      end
      FPEXC_OP_MOVE_IMM: begin
        wmask = field_bits(field_sel(cmd_i.field_idx)); // RULE4
        wdata = {NUM_FIELDS{cmd_i.imm}};
      end
      FPEXC_OP_SET_STATUS_BIT_ONE_INSTR: begin
        wmask = bit_sel(cmd_i.bit_idx); // RULE4
        wdata = '1;
      end
      FPEXC_OP_CLEAR_STATUS_BIT_ZERO_INSTR: begin
        wmask = bit_sel(cmd_i.bit_idx); // RULE4
        wdata = '0;
      end
      FPEXC_OP_READ_FIELD_TO_CR: begin
        clr = field_bits(field_sel(cmd_i.field_idx)) & CLEARABLE; // RULE3
      end
      FPEXC_OP_NONE: begin
        wmask = '0;
      end
      default: begin
        // Illegal code does nothing
        wmask = '0;
      end
    endcase
    // Summaries 1 and 2 are derived, so writes to them are dropped
    wmask     = wmask & WRITABLE_MASK;
    after_cmd = ((status_q & ~wmask) | (wdata & wmask)) & ~clr; // RULE12
    cmd_rise  = after_cmd & ~status_q & EXC_MASK;
    pipe_set  = done_i.valid ? (flags_word(done_i.flags) & EXC_MASK) : '0;
    pipe_rise = pipe_set & ~after_cmd;
    // Pipeline set wins over a same-cycle clear
    status_raw = (after_cmd | pipe_set) & IMPL_MASK; // RULE12
    if ((cmd_i.op == FPEXC_OP_SET_STATUS_BIT_ONE_INSTR) && (|cmd_rise)) begin
      status_raw[BIT_EXC_SUMMARY] = 1'b1; // RULE2
    end
    if (|pipe_rise) begin
      status_raw[BIT_EXC_SUMMARY] = 1'b1; // RULE1
    end
  end

  fpexc_summary u_summary (
    .status_i                    (status_raw),
    .enabled_exception_summary_o (enabled_sum_new),
    .invalid_op_summary_o        (invalid_sum_new)
  );

  // Final word under the clock enable
  always_comb begin
    status_d = status_raw;
    status_d[BIT_ENABLED_SUMMARY] = enabled_sum_new; // RULE5
    status_d[BIT_INVALID_SUMMARY] = invalid_sum_new; // RULE6
    if (!ce_i) begin
      status_d = status_q;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Field read-out to the condition register
  always_comb begin
    cr_field_d = cr_field_q;
    cr_valid_d = 1'b0;
    if (cmd_i.op == FPEXC_OP_READ_FIELD_TO_CR) begin
      // Copy taken before the clear so the reader sees the old flags
      cr_field_d = status_q[{cmd_i.field_idx, 2'b00} +: FIELD_W]; // RULE3
      cr_valid_d = 1'b1;
    end
    if (!ce_i) begin
      cr_field_d = cr_field_q;
      cr_valid_d = cr_valid_q;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cr_field_q <= CR_FIELD_RESET;
      cr_valid_q <= 1'b0;
    end else begin
      cr_field_q <= cr_field_d;
      cr_valid_q <= cr_valid_d;
    end
  end

  // Interrupt request
  always_comb begin
    // Any fresh exception flag while bit 1 is set, or bit 1 newly set by a flag or an enable
    new_enabled = enabled_sum_new &
                  (~status_q[BIT_ENABLED_SUMMARY] | (|(cmd_rise | pipe_rise)));
    irq_d = fp_interrupt_enable_i & new_enabled; // RULE11
    if (!ce_i) begin
      irq_d = irq_q;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign fp_status_control_o = status_q;
  assign cr_field_o          = cr_field_q;
  assign cr_valid_o          = cr_valid_q;
  assign fp_interrupt_o      = irq_q;

endmodule : fpexc_status

// file: fpexc_status_assertions.sv
`timescale 1ns/100ps
module fpexc_status_checker
  import fpexc_pkg::*;
(
  // Clock and reset
  input wire logic                      mclk_i,
  input wire logic                      reset_i,
  input wire logic                      ce_i,
  // Inputs
  input wire fpexc_pkg::fpexc_done_type done_i,
  input wire fpexc_pkg::fpexc_cmd_type  cmd_i,
  input wire logic                      fp_interrupt_enable_i,
  // Outputs
  input wire logic [0:31]               fp_status_control_o,
  input wire logic [0:3]                cr_field_o,
  input wire logic                      cr_valid_o,
  input wire logic                      fp_interrupt_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  wire [0:31] s  = fp_status_control_o;
  // Pipeline quiet, so a same-cycle set cannot mask the effect
  wire        go = ce_i && !done_i.valid;
  a_enabled_sum: assert property (s[1] == (|(s[3:6] & s[25:28]) | (s[2] & s[24])))
    else $error("enabled summary wrong");
  a_invalid_sum: assert property (s[2] == |s[7:12])
    else $error("invalid summary wrong");
  a_pipe_sets_sum: assert property (ce_i && done_i.valid && cmd_i.op == FPEXC_OP_NONE
    && |(done_i.flags & ~s[3:12]) |=> s[0]) else $error("pipeline raise missed summary");
  a_flags_sticky: assert property (ce_i && cmd_i.op == FPEXC_OP_NONE |=> s[3:12] ==
    ($past(s[3:12]) | ({10{$past(done_i.valid)}} & $past(done_i.flags))))
    else $error("flags not sticky");
  a_setbit_sum: assert property (ce_i && cmd_i.op == FPEXC_OP_SET_STATUS_BIT_ONE_INSTR
    && EXC_MASK[cmd_i.bit_idx] && !s[cmd_i.bit_idx] |=> s[0]) else $error("set bit missed summary");
  a_clear_sum: assert property (go && cmd_i.op == FPEXC_OP_CLEAR_STATUS_BIT_ZERO_INSTR
    && cmd_i.bit_idx == 5'h00 |=> !s[0]) else $error("clear bit failed");
  a_read_clears: assert property (go && cmd_i.op == FPEXC_OP_READ_FIELD_TO_CR
    && cmd_i.field_idx == 3'h0 |=> !s[0] && cr_valid_o && cr_field_o == $past(s[0:3]))
    else $error("read-out wrong");
  a_irq_cause: assert property (fp_interrupt_o |-> s[1] && $past(fp_interrupt_enable_i))
    else $error("interrupt without cause");
  a_ce_freeze: assert property (!ce_i |=> $stable(s) && $stable(cr_valid_o)
    && $stable(cr_field_o) && $stable(fp_interrupt_o)) else $error("clock enable did not freeze");
endmodule : fpexc_status_checker

bind fpexc_status fpexc_status_checker u_fpexc_status_checker (.mclk_i, .reset_i, .ce_i,
  .done_i, .cmd_i, .fp_interrupt_enable_i, .fp_status_control_o, .cr_field_o, .cr_valid_o,
  .fp_interrupt_o);

// file: fpexc_summary.sv
`timescale 1ns/100ps
module fpexc_summary
  import fpexc_pkg::*;
(
  // Raw status word
  input  wire logic [0:31] status_i,
  // Summaries
  output logic             enabled_exception_summary_o,
  output logic             invalid_op_summary_o
);

  logic invalid_any;

  always_comb begin
    invalid_any = |(status_i & INVALID_MASK); // RULE6 RULE9
    invalid_op_summary_o = invalid_any; // RULE6
    enabled_exception_summary_o =
      (invalid_any                 & status_i[BIT_INVALID_ENABLE])   |
      (status_i[BIT_OVERFLOW]      & status_i[BIT_OVERFLOW_ENABLE])  |
      (status_i[BIT_UNDERFLOW]     & status_i[BIT_UNDERFLOW_ENABLE]) |
      (status_i[BIT_ZERO_DIVIDE]   & status_i[BIT_ZERO_DIV_ENABLE])  |
      (status_i[BIT_INEXACT]       & status_i[BIT_INEXACT_ENABLE]); // RULE5 RULE10
  end

endmodule : fpexc_summary

// file: tb_fp_exception_status_bits.sv
`timescale 1ns/100ps
module tb_fp_exception_status_bits;
  import fpexc_pkg::*;
  typedef struct packed {int due; logic irq; logic crv; logic [0:3] crf; logic [0:31] s;} fpexc_exp_type;
  logic            mclk_i, reset_i, ce_i, fp_interrupt_enable_i, issue, crv, irq, pv, ce_nx;
  fpexc_flags_type flags;
  fpexc_done_type  done;
  fpexc_cmd_type   cmd;
  logic [0:31]     sts, m;
  logic [0:3]      crf, mcrf;
  logic [0:9]      pf;
  logic [63:0]     r;
  int              errors, cmp_count, cyc;
  fpexc_exp_type   q[$], pe;
  fpexc_op_type    ops[7] = '{FPEXC_OP_NONE, FPEXC_OP_MOVE_FIELDS, FPEXC_OP_MOVE_IMM,
    FPEXC_OP_SET_STATUS_BIT_ONE_INSTR, FPEXC_OP_CLEAR_STATUS_BIT_ZERO_INSTR,
    FPEXC_OP_READ_FIELD_TO_CR, fpexc_op_type'(6'h03)};

  fpexc_status u_fpexc_status (.mclk_i, .reset_i, .ce_i, .done_i(done), .cmd_i(cmd),
    .fp_interrupt_enable_i, .fp_status_control_o(sts), .cr_field_o(crf), .cr_valid_o(crv),
    .fp_interrupt_o(irq));
  fpexc_pipe_model u_fpexc_pipe_model (.mclk_i, .reset_i, .issue_i(issue), .flags_i(flags),
    .done_o(done));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) cyc++;

  task automatic check(logic [0:31] seen, logic [0:31] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(negedge mclk_i) while (q.size() > 0 && q[0].due <= cyc) begin
    check(sts, q[0].s);
    check(32'({crv, crf}), 32'({q[0].crv, q[0].crf}));
    check(32'(irq), 32'(q[0].irq));
    void'(q.pop_front());
  end

  // Done reaches the block one cycle after issue, so it pairs with the next command
  task automatic step(fpexc_op_type op, logic [0:7] mk, logic [4:0] n, logic [0:3] imm,
                      logic [0:31] d, logic v, logic [0:9] f, logic ie);
    logic [0:31]   x;
    logic [0:9]    nw;
    fpexc_exp_type e;
    @(negedge mclk_i);
    cmd = '{op, mk, n[2:0], imm, n, d};
    issue = v;
    flags = f;
    fp_interrupt_enable_i = ie;
    ce_i = ce_nx;
    x = m;
    e = '0;
    e.crf = mcrf;
    e.due = cyc + 1;
    case (op)
      FPEXC_OP_MOVE_FIELDS: for (int i = 0; i < 8; i++) if (mk[i]) x[4*i+:4] = d[4*i+:4];
      FPEXC_OP_MOVE_IMM: x[4*n[2:0]+:4] = imm;
      FPEXC_OP_SET_STATUS_BIT_ONE_INSTR: x[n] = 1'b1;
      FPEXC_OP_CLEAR_STATUS_BIT_ZERO_INSTR: x[n] = 1'b0;
      FPEXC_OP_READ_FIELD_TO_CR: begin
        e.crf = m[4*n[2:0]+:4];
        e.crv = 1'b1;
        x[4*n[2:0]+:4] &= ~CLEARABLE[4*n[2:0]+:4];
      end
      default: ;
    endcase
    x &= WRITABLE_MASK;
    if (op == FPEXC_OP_SET_STATUS_BIT_ONE_INSTR && EXC_MASK[n] && !m[n]) x[0] = 1'b1;
    nw = {10{pv}} & pf & ~x[3:12];
    x[3:12] |= nw;
    if (|nw) x[0] = 1'b1;
    x[2] = |x[7:12];
    x[1] = |(x[3:6] & x[25:28]) | (x[2] & x[24]);
    e.irq = ie && x[1] && (|((x[3:12] & ~m[3:12]) | nw) || !m[1]);
    // Frozen cycle: outputs hold and the completion is lost
    if (!ce_i) begin
      e = pe;
      e.due = cyc + 1;
      x = m;
    end
    e.s = x;
    m = x;
    mcrf = e.crf;
    pv = v;
    pf = f;
    q.push_back(e);
    pe = e;
  endtask : step

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial begin
    #100000;
    errors++;
    final_report;
  end

  initial begin
    {ce_i, reset_i, issue, fp_interrupt_enable_i, pv, m, mcrf, pf} = '0;
    ce_i = 1'b1;
    ce_nx = 1'b1;
    pe = '0;
    reset_i = 1'b1;
    flags = '0;
    cmd = '0;
    cmd.op = FPEXC_OP_NONE;
    void'($urandom(44));
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i) reset_i = 1'b0;
    step(FPEXC_OP_NONE, 8'h00, 5'd0, 4'h0, 32'h0, 1'b0, 10'h000, 1'b0);
    $display("test reset done");
    step(FPEXC_OP_MOVE_IMM, 8'h00, 5'd6, 4'h4, 32'h0, 1'b1, 10'h200, 1'b1);
    step(FPEXC_OP_NONE, 8'h00, 5'd0, 4'h0, 32'h0, 1'b1, 10'h200, 1'b1);
    step(FPEXC_OP_NONE, 8'h00, 5'd0, 4'h0, 32'h0, 1'b0, 10'h000, 1'b1);
    step(FPEXC_OP_READ_FIELD_TO_CR, 8'h00, 5'd0, 4'h0, 32'h0, 1'b0, 10'h000, 1'b1);
    step(FPEXC_OP_SET_STATUS_BIT_ONE_INSTR, 8'h00, 5'd5, 4'h0, 32'h0, 1'b0, 10'h000, 1'b1);
    step(FPEXC_OP_CLEAR_STATUS_BIT_ZERO_INSTR, 8'h00, 5'd0, 4'h0, 32'h0, 1'b0, 10'h000, 1'b1);
    step(FPEXC_OP_SET_STATUS_BIT_ONE_INSTR, 8'h00, 5'd12, 4'h0, 32'h0, 1'b0, 10'h000, 1'b1);
    step(FPEXC_OP_MOVE_FIELDS, 8'hFF, 5'd0, 4'h0, 32'hFFFF_FFFF, 1'b0, 10'h000, 1'b1);
    step(FPEXC_OP_MOVE_FIELDS, 8'hFF, 5'd0, 4'h0, 32'h0, 1'b0, 10'h000, 1'b1);
    $display("test directed done");
    for (int i = 0; i < 400; i++) begin
      r = {$urandom, $urandom};
      ce_nx = r[29] | r[30];
      step(ops[$urandom_range(6)], r[7:0], r[12:8], r[16:13], r[63:32], r[17], r[27:18],
           ce_nx ? r[28] : fp_interrupt_enable_i);
    end
    $display("test random done");
    repeat (2) @(negedge mclk_i);
    final_report;
  end
endmodule : tb_fp_exception_status_bits
